// file: logic/tiv_trip_voter.sv
`timescale 1ns/1ps
// serial lane receiver with coding, parity and refresh checks
module tiv_link_rx
   import tiv_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = REFRESH_DEF
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // lane pins
   input wire logic lclk,
   input wire logic ldat,
   // received word and its health
   output logic [DATA_W-1:0] payload,
   output logic valid,
   output logic good,
   output logic bad
);
   typedef enum logic [1:0] {
      RX_HUNT = 2'b01,
      RX_BODY = 2'b10
   } tiv_rx_state_t;

   tiv_rx_state_t state;
   logic [1:0] clk_sync;
   logic [1:0] dat_sync;
   logic clk_d;
   logic [BODY_HALVES-2:0] hist;
   logic [4:0] cnt;
   logic [15:0] age;

   // link clock edges found by our own clock, after two flops
   wire rise = clk_sync[1] & ~clk_d;
   wire [BODY_HALVES-1:0] word_in = {hist, dat_sync[1]};
   wire sync_hit = rise && (state == RX_HUNT) && (word_in[5:0] == SYNC_PAT);
   wire body_done = rise && (state == RX_BODY) && (cnt == 5'(BODY_HALVES - 1));
   wire word_ok = tiv_body_ok(word_in);
   wire aged_out = age >= 16'(REFRESH_CYC);

   // synchronisers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         clk_sync <= 2'h0;
         dat_sync <= 2'h0;
         clk_d <= 1'b0;
      end else begin
         clk_sync <= {clk_sync[0], lclk};
         dat_sync <= {dat_sync[0], ldat};
         clk_d <= clk_sync[1];
      end
   end

   // half-bit history; a run of three equal halves never occurs in data
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hist <= '0;
      end else if (rise) begin
         hist <= word_in[BODY_HALVES-2:0];
      end
   end

   // frame tracker
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= RX_HUNT;
         cnt <= 5'h00;
      end else begin
         case (state)
            RX_HUNT: begin
               cnt <= 5'h00;
               if (sync_hit) begin
                  state <= RX_BODY;
               end
            end
            RX_BODY: begin
               if (rise) begin
                  cnt <= cnt + 5'h01;
               end
               if (body_done) begin
                  state <= RX_HUNT;
               end
            end
            default: begin
               state <= RX_HUNT;
            end
         endcase
      end
   end

   // a word failing coding or parity is dropped and only flagged
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         payload <= '0;
         good <= 1'b0;
         bad <= 1'b0;
      end else begin
         good <= body_done & word_ok; // RULE7
         bad <= body_done & ~word_ok; // RULE7
         if (body_done & word_ok) begin
            payload <= tiv_decode(word_in);
         end
      end
   end

   // age starts expired so nothing counts as fresh before a first good word
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         age <= 16'(REFRESH_CYC); // RULE14
      end else if (good) begin
         age <= 16'h0000;
      end else if (!aged_out) begin
         age <= age + 16'h0001; // RULE6
      end
   end

   assign valid = ~aged_out; // RULE8
endmodule

// Contract
// RULE1: four trip inputs, one per calculator
// RULE2: each calculator drives one output per voter
// RULE3: point-to-point manchester serial links carry trip status
// RULE4: two-out-of-four vote forms divisional trip
// RULE5: sensor bypass ignores one selected calculator; code ignores it in the reactor trip vote only
// RULE6: status retransmitted continuously; stale status invalid
// RULE7: reject words failing parity or manchester check
// RULE8: stale or invalid input forced tripped alone
// RULE9: send mode status, receive range monitor trips
// RULE10: neutron monitor link validated and fails tripped
// RULE11: trip command whenever voted trip exists
// RULE12: sensor and steam-line bypasses are inputs
// RULE13: timeout parameter; bypass gives two-of-three vote; the code does so in the reactor trip vote only, isolation stays two-of-four
// RULE14: inputs tripped from reset until first good word
module tiv_trip_voter
   import tiv_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = REFRESH_DEF
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // serial lanes
   tiv_link_if.voter_end link,
   // bypass controls and mode
   input wire logic sensor_bypass_en,
   input wire logic [1:0] sensor_bypass_sel,
   input wire logic steam_bypass,
   input wire logic [MODE_W-1:0] mode_status,
   // trip commands to the output logic unit
   output logic rp_trip_cmd,
   output logic iso_trip_cmd,
   // range monitor trips, forced on when their lane fails
   output logic sr_trip,
   output logic pr_trip,
   // health: index 4 is the neutron monitor lane
   output logic [N_CH:0] input_fault,
   output logic [N_CH:0] reject
);
   logic [DATA_W-1:0] ch_word [N_CH];
   logic [N_CH-1:0] ch_valid;
   logic [N_CH-1:0] ch_bad;
   logic [DATA_W-1:0] nm_word;
   logic nm_valid;
   logic nm_bad;
   logic [N_CH-1:0] rp_in;
   logic [N_CH-1:0] iso_in;

   // true when at least two of the four are set
   function automatic logic vote2(input logic [N_CH-1:0] t);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < N_CH; i++) begin
         n = n + {2'h0, t[i]};
      end
      return n >= 3'h2;
   endfunction

   // one receiver per calculator; a dead lane trips only its own input
   for (genvar g = 0; g < N_CH; g++) begin : g_ch
      tiv_link_rx #(.REFRESH_CYC(REFRESH_CYC)) u_rx ( // RULE1 RULE3 RULE13
         .clock(clock),
         .rst(rst),
         .lclk(link.calc_clk[g]),
         .ldat(link.calc_dat[g]),
         .payload(ch_word[g]),
         .valid(ch_valid[g]),
         .good(),
         .bad(ch_bad[g])
      );
      assign rp_in[g] = ~ch_valid[g] | ch_word[g][TRIP_RP_BIT]; // RULE8
      assign iso_in[g] = ~ch_valid[g] | ch_word[g][TRIP_ISO_BIT]; // RULE8
   end

   // neutron monitor lane, same checks as the calculator lanes
   tiv_link_rx #(.REFRESH_CYC(REFRESH_CYC)) u_nm_rx ( // RULE9 RULE10
      .clock(clock),
      .rst(rst),
      .lclk(link.nm_clk),
      .ldat(link.nm_dat),
      .payload(nm_word),
      .valid(nm_valid),
      .good(),
      .bad(nm_bad)
   );

   // mode status goes back to the neutron monitor voter
   tiv_link_tx u_mode_tx ( // RULE9
      .clock(clock),
      .rst(rst),
      .payload(DATA_W'(mode_status)),
      .lclk(link.mode_clk),
      .ldat(link.mode_dat)
   );

   // a bypassed channel counts as not tripped in the reactor trip vote, leaving two-of-three
   wire [N_CH-1:0] byp_mask = sensor_bypass_en ? (4'h1 << sensor_bypass_sel) : 4'h0; // RULE5 RULE12
   wire [N_CH-1:0] rp_vote_in = rp_in & ~byp_mask; // RULE5 RULE13
   wire rp_voted = vote2(rp_vote_in); // RULE4
   // the steam-line operational bypass only holds off the isolation command
   wire iso_voted = vote2(iso_in) & ~steam_bypass; // RULE4 RULE12

   // registered outputs; one cycle from input change to command
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rp_trip_cmd <= 1'b1;
         iso_trip_cmd <= 1'b1;
         sr_trip <= 1'b1;
         pr_trip <= 1'b1;
      end else begin
         rp_trip_cmd <= rp_voted; // RULE11
         iso_trip_cmd <= iso_voted;
         sr_trip <= ~nm_valid | nm_word[NM_SR_BIT]; // RULE10
         pr_trip <= ~nm_valid | nm_word[NM_PR_BIT]; // RULE10
      end
   end

   // health status
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         input_fault <= '1;
         reject <= '0;
      end else begin
         input_fault <= ~{nm_valid, ch_valid};
         reject <= {nm_bad, ch_bad};
      end
   end
endmodule

// file: logic/tiv_pkg.sv
package tiv_pkg;
   // clock and link timing
   localparam int CLK_NS = 4;
   localparam int LINK_NS = 48;
   localparam int HALF_CYC = LINK_NS / CLK_NS;
   localparam int HALF_HI = HALF_CYC / 2;
   // refresh timeout, least time rounded up to whole cycles
   localparam int REFRESH_NS = 5000;
   localparam int REFRESH_DEF = (REFRESH_NS + CLK_NS - 1) / CLK_NS;
   // frame layout in half-bit cells: sync, manchester data, manchester parity
   localparam int N_CH = 4;
   localparam int DATA_W = 8;
   localparam int SYNC_HALVES = 6;
   localparam int BODY_HALVES = 2 * DATA_W + 2;
   localparam int FRAME_HALVES = SYNC_HALVES + BODY_HALVES;
   localparam logic [5:0] SYNC_PAT = 6'h38;
   // payload fields
   localparam int TRIP_RP_BIT = 0;
   localparam int TRIP_ISO_BIT = 1;
   localparam int NM_SR_BIT = 0;
   localparam int NM_PR_BIT = 1;
   localparam int MODE_W = 3;

   // manchester ii: one is high then low, zero is low then high; odd parity last
   function automatic logic [BODY_HALVES-1:0] tiv_encode(input logic [DATA_W-1:0] d);
      logic [BODY_HALVES-1:0] h;
      h = '0;
      for (int i = 0; i < DATA_W; i++) begin
         h[BODY_HALVES-1-2*i -: 2] = d[DATA_W-1-i] ? 2'h2 : 2'h1;
      end
      h[1:0] = (~^d) ? 2'h2 : 2'h1;
      return h;
   endfunction

   // data bit is the first half of each cell
   function automatic logic [DATA_W-1:0] tiv_decode(input logic [BODY_HALVES-1:0] h);
      logic [DATA_W-1:0] d;
      d = '0;
      for (int i = 0; i < DATA_W; i++) begin
         d[DATA_W-1-i] = h[BODY_HALVES-1-2*i];
      end
      return d;
   endfunction

   // every cell must hold a transition, and data plus parity must be odd
   function automatic logic tiv_body_ok(input logic [BODY_HALVES-1:0] h);
      logic ok;
      ok = 1'b1;
      for (int k = 0; k < BODY_HALVES / 2; k++) begin
         if (h[2*k+1] == h[2*k]) begin
            ok = 1'b0;
         end
      end
      return ok & (^{tiv_decode(h), h[1]});
   endfunction
endpackage

// file: logic/tiv_link_if.sv
`timescale 1ns/1ps
interface tiv_link_if;
   import tiv_pkg::*;
   // calculator to voter lanes, one per division
   logic [N_CH-1:0] calc_clk;
   logic [N_CH-1:0] calc_dat;
   // neutron monitor voter to voter lane
   logic nm_clk;
   logic nm_dat;
   // voter to neutron monitor voter lane, mode status
   logic mode_clk;
   logic mode_dat;

   modport voter_end (
      input calc_clk,
      input calc_dat,
      input nm_clk,
      input nm_dat,
      output mode_clk,
      output mode_dat
   );

   modport far_end (
      output calc_clk,
      output calc_dat,
      output nm_clk,
      output nm_dat,
      input mode_clk,
      input mode_dat
   );
endinterface

// file: logic/tiv_far_end.sv
`timescale 1ns/1ps
// serial lane transmitter: link clock from a divider, frames sent back to back
module tiv_link_tx
   import tiv_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // word to send, sampled at each frame start
   input wire logic [DATA_W-1:0] payload,
   // lane pins
   output logic lclk,
   output logic ldat
);
   logic [3:0] phase;
   logic [4:0] half_idx;
   logic [FRAME_HALVES-1:0] shreg;

   wire half_end = phase == 4'(HALF_CYC - 1);
   wire last_half = half_idx == 5'(FRAME_HALVES - 1);
   wire frame_load = half_end & last_half;

   // half-bit divider
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase <= 4'h0;
      end else begin
         phase <= half_end ? 4'h0 : phase + 4'h1;
      end
   end

   // position inside the frame
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         half_idx <= 5'h00;
      end else if (half_end) begin
         half_idx <= last_half ? 5'h00 : half_idx + 5'h01;
      end
   end

   // retransmit without a gap so the far end can see staleness once its refresh timeout runs out
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shreg <= '0;
      end else if (frame_load) begin
         shreg <= {SYNC_PAT, tiv_encode(payload)}; // RULE3 RULE6
      end else if (half_end) begin
         shreg <= {shreg[FRAME_HALVES-2:0], 1'b0};
      end
   end

   // data moves on the falling clock edge, so it is settled at the rising one
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lclk <= 1'b0;
      end else if (phase == 4'(HALF_HI - 1)) begin
         lclk <= 1'b1;
      end else if (half_end) begin
         lclk <= 1'b0;
      end
   end

   assign ldat = shreg[FRAME_HALVES-1];
endmodule

// the four channel trip calculators and the neutron monitor voter, as one bench-facing end
module tiv_far_end
   import tiv_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = REFRESH_DEF
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // serial lanes
   tiv_link_if.far_end link,
   // calculator trip decisions, one bit per division
   input wire logic [N_CH-1:0] calc_rp_trip,
   input wire logic [N_CH-1:0] calc_iso_trip,
   // range monitor trips
   input wire logic sr_trip_in,
   input wire logic pr_trip_in,
   // mode status received from the voter
   output logic [MODE_W-1:0] mode_rx,
   output logic mode_valid,
   output logic mode_reject
);
   logic [DATA_W-1:0] mode_word;

   // each calculator keeps sending its status without pause
   for (genvar g = 0; g < N_CH; g++) begin : g_calc
      tiv_link_tx u_tx ( // RULE2 RULE6
         .clock(clock),
         .rst(rst),
         .payload({6'h00, calc_iso_trip[g], calc_rp_trip[g]}),
         .lclk(link.calc_clk[g]),
         .ldat(link.calc_dat[g])
      );
   end

   // range monitor trips toward the voter
   tiv_link_tx u_nm_tx ( // RULE10
      .clock(clock),
      .rst(rst),
      .payload({6'h00, pr_trip_in, sr_trip_in}),
      .lclk(link.nm_clk),
      .ldat(link.nm_dat)
   );

   // mode lane checked like every other lane
   tiv_link_rx #(.REFRESH_CYC(REFRESH_CYC)) u_mode_rx ( // RULE3 RULE10
      .clock(clock),
      .rst(rst),
      .lclk(link.mode_clk),
      .ldat(link.mode_dat),
      .payload(mode_word),
      .valid(mode_valid),
      .good(),
      .bad(mode_reject)
   );

   assign mode_rx = mode_word[MODE_W-1:0];
endmodule

// file: testbench/tiv_link_props.sv
`timescale 1ns/1ps
// lane timing watcher on the link between the two design ends
module tiv_link_props
   import tiv_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // lane signals
   input wire logic [N_CH-1:0] calc_clk,
   input wire logic [N_CH-1:0] calc_dat,
   input wire logic nm_clk,
   input wire logic nm_dat,
   input wire logic mode_clk,
   input wire logic mode_dat
);
   // one domain, so clocking and reset are given once
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_calc_high_six: assert property ($rose(calc_clk[0]) |-> calc_clk[0][*6] ##1 !calc_clk[0])
      else $error("calc lane clock high time wrong");
   a_calc_low_six: assert property ($fell(calc_clk[3]) |-> !calc_clk[3][*6] ##1 calc_clk[3])
      else $error("calc lane clock low time wrong");
   a_calc_refresh: assert property ($rose(calc_clk[1]) |-> ##12 $rose(calc_clk[1]))
      else $error("calc lane stopped refreshing");
   // a data bit may only move where its own lane clock just fell
   a_calc_dat_edge: assert property ($changed(calc_dat) |->
      (((calc_dat ^ $past(calc_dat)) & (calc_clk | ~$past(calc_clk))) == '0))
      else $error("calc lane data moved off a clock fall");
   a_nm_period: assert property ($rose(nm_clk) |-> ##12 $rose(nm_clk))
      else $error("monitor lane stopped refreshing");
   a_nm_dat_edge: assert property ($changed(nm_dat) |-> $fell(nm_clk))
      else $error("monitor lane data moved off a clock fall");
   a_mode_high_six: assert property ($rose(mode_clk) |-> mode_clk[*6] ##1 !mode_clk)
      else $error("mode lane clock high time wrong");
   a_mode_dat_edge: assert property ($changed(mode_dat) |-> $fell(mode_clk))
      else $error("mode lane data moved off a clock fall");
endmodule

// file: testbench/test_trip_input_voter.sv
`timescale 1ns/1ps
// far end against voter, plus a second voter fed by a hand-made lane driver
module test_trip_input_voter;
   import tiv_pkg::*;
   // short timeout keeps the stale test brief; still longer than one frame
   localparam int unsigned REFRESH_SMALL = 400;
   localparam int SETTLE = 2 * FRAME_HALVES * HALF_CYC + 24;
   localparam logic [6:0] CORNER [4] = '{7'h01, 7'h03, 7'h43, 7'h57};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [N_CH-1:0] calc_rp = '0;
   logic [N_CH-1:0] calc_iso = '0;
   logic sr_in = 1'b0;
   logic pr_in = 1'b0;
   logic byp_en = 1'b0;
   logic [1:0] byp_sel = 2'h0;
   logic steam = 1'b0;
   logic [MODE_W-1:0] mode = '0;
   logic rp_cmd, iso_cmd, sr_out, pr_out, mode_ok, rp2, sr2;
   logic [N_CH:0] fault, fault2, reject2, seen;
   logic [MODE_W-1:0] mode_got;
   logic [N_CH:0] rej1;
   logic mode_bad;
   logic noise = 1'b0;
   logic [31:0] seed = 32'h8439ED58;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;

   tiv_link_if link();
   tiv_link_if link2();

   tiv_far_end #(.REFRESH_CYC(REFRESH_SMALL)) tiv_far_end_inst (.clock(clock), .rst(rst), .link(link),
      .calc_rp_trip(calc_rp), .calc_iso_trip(calc_iso), .sr_trip_in(sr_in), .pr_trip_in(pr_in),
      .mode_rx(mode_got), .mode_valid(mode_ok), .mode_reject(mode_bad));
   tiv_trip_voter #(.REFRESH_CYC(REFRESH_SMALL)) tiv_trip_voter_inst (.clock(clock), .rst(rst), .link(link),
      .sensor_bypass_en(byp_en), .sensor_bypass_sel(byp_sel), .steam_bypass(steam), .mode_status(mode),
      .rp_trip_cmd(rp_cmd), .iso_trip_cmd(iso_cmd), .sr_trip(sr_out), .pr_trip(pr_out),
      .input_fault(fault), .reject(rej1));
   tiv_trip_voter #(.REFRESH_CYC(REFRESH_SMALL)) tiv_trip_voter_inst2 (.clock(clock), .rst(rst), .link(link2),
      .sensor_bypass_en(byp_en), .sensor_bypass_sel(byp_sel), .steam_bypass(steam), .mode_status(mode),
      .rp_trip_cmd(rp2), .iso_trip_cmd(), .sr_trip(sr2), .pr_trip(),
      .input_fault(fault2), .reject(reject2));
   tiv_link_props tiv_link_props_inst (.clock(clock), .rst(rst), .calc_clk(link.calc_clk),
      .calc_dat(link.calc_dat), .nm_clk(link.nm_clk), .nm_dat(link.nm_dat),
      .mode_clk(link.mode_clk), .mode_dat(link.mode_dat));

   // 4 ns clock
   always #2 clock = ~clock;

   // clean lanes must never flag a frame; pulses last one cycle, so every falling edge looks
   always @(negedge clock) begin
      if (rej1 !== '0 || mode_bad !== 1'b0) begin
         noise = 1'b1;
      end
   end

   // hang guard, well above the planned run of about 9000 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("BAD %0t run timed out", $time);
         finish_test();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // two or more unmasked trips out of four
   function automatic logic vote(input logic [3:0] trip, input logic [3:0] mask);
      return $countones(trip & ~mask) >= 2;
   endfunction

   // frame in half cells: sync, data msb first, odd parity; flaws on request
   function automatic logic [23:0] frame_of(input logic [7:0] d, input logic bad_par, input logic bad_cell);
      logic [23:0] f;
      f = {SYNC_PAT, 18'h0};
      for (int i = 0; i < 8; i++) begin
         f[17-2*i -: 2] = d[7-i] ? 2'h2 : 2'h1;
      end
      f[1:0] = (~^d ^ bad_par) ? 2'h2 : 2'h1;
      if (bad_cell) begin
         f[9:8] = 2'h3;
      end
      return f;
   endfunction

   task automatic check(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   // one frame on every calculator and monitor lane of the second link, then a short gap with the clock parked low
   task automatic send(input logic [23:0] f);
      logic ck, dt;
      seen = '0;
      for (int c = 0; c < FRAME_HALVES * HALF_CYC + 8; c++) begin
         @(posedge clock);
         #1;
         ck = (c < FRAME_HALVES * HALF_CYC) && (c % HALF_CYC >= HALF_HI);
         dt = (c < FRAME_HALVES * HALF_CYC) ? f[FRAME_HALVES - 1 - c / HALF_CYC] : ~f[0];
         link2.calc_clk = {N_CH{ck}};
         link2.calc_dat = {N_CH{dt}};
         link2.nm_clk = ck;
         link2.nm_dat = dt;
         @(negedge clock);
         seen = seen | reject2;
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      link2.calc_clk = '0;
      link2.calc_dat = '0;
      link2.nm_clk = 1'b0;
      link2.nm_dat = 1'b0;
      repeat (6) @(posedge clock);
      #1;
      rst = 1'b0;
      repeat (50) @(posedge clock);
      #1;
      check(rp_cmd === 1'b1 && fault === 5'h1F && sr_out === 1'b1, "trips not held after reset");
      // bad frames carry trip bits, so a wrongly taken one would show as a trip
      send(frame_of(8'h00, 1'b0, 1'b0));
      check(fault2 === 5'h00 && rp2 === 1'b0 && sr2 === 1'b0, "good frame not taken");
      send(frame_of(8'h03, 1'b1, 1'b0));
      check(seen === 5'h1F && rp2 === 1'b0 && fault2 === 5'h00, "bad parity frame taken");
      send(frame_of(8'h00, 1'b0, 1'b0));
      send(frame_of(8'h03, 1'b0, 1'b1));
      check(seen === 5'h1F && rp2 === 1'b0 && sr2 === 1'b0, "broken coding frame taken");
      repeat (REFRESH_SMALL) @(posedge clock);
      #1;
      check(fault2 === 5'h1F && rp2 === 1'b1 && sr2 === 1'b1, "stale lanes not tripped");
      $display("test fault lanes done");
      // corner votes first, then random ones
      for (int t = 0; t < 12; t++) begin
         @(posedge clock);
         #1;
         seed = lfsr(seed);
         {byp_en, byp_sel, calc_rp} = (t < 4) ? CORNER[t] : seed[6:0];
         {calc_iso, steam, sr_in, pr_in, mode} = seed[16:7];
         repeat (SETTLE) @(posedge clock);
         #1;
         check(rp_cmd === vote(calc_rp, byp_en ? 4'h1 << byp_sel : 4'h0), "reactor vote wrong");
         check(iso_cmd === (~steam & vote(calc_iso, 4'h0)), "isolation vote wrong");
         check({sr_out, pr_out} === {sr_in, pr_in} && fault === 5'h00, "monitor trips wrong");
         check(mode_got === mode && mode_ok === 1'b1, "mode status wrong");
         $display("test %0d done", t);
      end
      check(noise === 1'b0, "clean lane frame rejected");
      finish_test();
   end
endmodule
